// >>> hw/ris_pkg.sv
// Package: constants, register map and encodings of the reference input scaling block
package ris_pkg;

  // ----------------------------------------------------------------
  // Data formats
  // ----------------------------------------------------------------
  localparam int RIS_SAMPLE_W = 16;
  localparam int RIS_PARAM_W = 16;
  localparam int RIS_WIDE_W = 34;
  localparam int RIS_AUX_N = 3;
  // A sample of 10 V full scale reads as this count
  localparam logic signed [RIS_WIDE_W-1:0] RIS_FULL_SCALE = 34'sh000004000;
  // Settings are held in tenths of a percent, so percent/100 becomes tenths/1000
  localparam logic signed [RIS_WIDE_W-1:0] RIS_PCT_DIV = 34'sh0000003E8;
  localparam logic signed [RIS_WIDE_W-1:0] RIS_OUT_MAX = 34'sh000007FFF;
  localparam logic signed [RIS_WIDE_W-1:0] RIS_OUT_MIN = -34'sh000008000;

  // ----------------------------------------------------------------
  // Setting limits and values after reset (tenths of a percent)
  // ----------------------------------------------------------------
  localparam logic signed [RIS_PARAM_W-1:0] RIS_GAIN_MAX = 16'sh1F40;
  localparam logic signed [RIS_PARAM_W-1:0] RIS_GAIN_MIN = -16'sh1F40;
  localparam logic signed [RIS_PARAM_W-1:0] RIS_BIAS_MAX = 16'sh0FA0;
  localparam logic signed [RIS_PARAM_W-1:0] RIS_BIAS_MIN = -16'sh0FA0;
  localparam logic signed [RIS_PARAM_W-1:0] RIS_GAIN_RESET = 16'sh03E8;
  localparam logic signed [RIS_PARAM_W-1:0] RIS_BIAS_RESET = 16'sh0000;

  // ----------------------------------------------------------------
  // Sign modes
  // ----------------------------------------------------------------
  localparam logic [1:0] RIS_MODE_BIPOLAR = 2'h0;
  localparam logic [1:0] RIS_MODE_POS_ONLY = 2'h1;
  localparam logic [1:0] RIS_MODE_NEG_ONLY = 2'h2;
  localparam logic [1:0] RIS_MODE_RESET = 2'h0;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] RIS_OFF_SPEED_GAIN = 8'h00;
  localparam logic [7:0] RIS_OFF_SPEED_BIAS = 8'h04;
  localparam logic [7:0] RIS_OFF_SPEED_POL = 8'h08;
  localparam logic [7:0] RIS_OFF_CURR_GAIN = 8'h0C;
  localparam logic [7:0] RIS_OFF_CURR_BIAS = 8'h10;
  localparam logic [7:0] RIS_OFF_CURR_POL = 8'h14;
  // Aux input k uses base + k*stride for gain, +4 bias, +8 sign mode
  localparam logic [7:0] RIS_OFF_AUX_BASE = 8'h18;
  localparam logic [7:0] RIS_OFF_AUX_STRIDE = 8'h0C;
  localparam logic [7:0] RIS_OFF_STATUS = 8'h3C;
  localparam logic [7:0] RIS_OFF_MAIN_OUT = 8'h40;
  localparam logic [7:0] RIS_OFF_AUX_OUT = 8'h44;

endpackage : ris_pkg

// >>> hw/ris_scale.sv
// Module: one gain, bias, saturation and sign clamp channel
`timescale 1ns/100ps
`default_nettype none
module ris_scale
  import ris_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic in_valid,
  input wire logic signed [RIS_SAMPLE_W-1:0] sample,
  input wire logic signed [RIS_PARAM_W-1:0] gain,
  input wire logic signed [RIS_PARAM_W-1:0] bias,
  input wire logic [1:0] sign_mode,
  output logic signed [RIS_SAMPLE_W-1:0] out_ref,
  output logic out_valid
);

  logic signed [RIS_WIDE_W-1:0] prod;
  logic signed [RIS_WIDE_W-1:0] offs;
  logic signed [RIS_WIDE_W-1:0] quot;
  logic signed [RIS_SAMPLE_W-1:0] sat;
  logic signed [RIS_SAMPLE_W-1:0] next_out_ref;

  // Gain applied before the bias is summed, one division for both terms
  assign prod = RIS_WIDE_W'(sample) * RIS_WIDE_W'(gain); // see [RULE1] see [RULE3]
  assign offs = RIS_WIDE_W'(bias) * RIS_FULL_SCALE; // see [RULE6] see [RULE12]
  assign quot = (prod + offs) / RIS_PCT_DIV;

  // Extreme settings can exceed the sample range; clip instead of wrapping
  always_comb
  begin
    if (quot > RIS_OUT_MAX)
      sat = RIS_SAMPLE_W'(RIS_OUT_MAX); // see [RULE13]
    else if (quot < RIS_OUT_MIN)
      sat = RIS_SAMPLE_W'(RIS_OUT_MIN); // see [RULE13]
    else
      sat = quot[RIS_SAMPLE_W-1:0];
  end

  always_comb
  begin
    next_out_ref = sat;
    if (sign_mode == RIS_MODE_POS_ONLY && sat < 0)
      next_out_ref = '0; // see [RULE5] see [RULE10]
    else if (sign_mode == RIS_MODE_NEG_ONLY && sat > 0)
      next_out_ref = '0; // see [RULE5] see [RULE10]
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      out_ref <= '0;
    else if (in_valid)
      out_ref <= next_out_ref; // see [RULE13]
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      out_valid <= 1'b0;
    else
      out_valid <= in_valid;
  end

endmodule : ris_scale
`default_nettype wire

// >>> hw/ris_top.sv
// Module: reference input scaling datapath with Avalon-MM settings registers
//
// Behaviour
// [RULE1] With the slave input open the main sample is scaled by the speed gain and the speed bias is added.
// [RULE2] The speed gain is settable from -800.0 to 800.0 percent, resets to 100.0 and acts before the bias.
// [RULE3] With the slave input closed the main sample is scaled by the current gain plus the current bias.
// [RULE4] The current sign mode resets to 0 and after gain and bias selects bipolar, positive or negative.
// [RULE5] A unipolar main sign mode forces a result of the opposite sign to zero.
// [RULE6] The current bias spans -400.0 to 400.0 percent of 10 V, resets to zero and is the zero-input output.
// [RULE7] The current gain spans -800.0 to 800.0 percent, resets to 100.0 and acts before the current bias.
// [RULE8] For a slave fed 5 V at nominal current, software should set the current gain to 200 percent.
// [RULE9] Each of the three aux inputs has its own sign mode, reset to 0, applied after its gain and bias.
// [RULE10] A unipolar aux sign mode replaces an aux result of the opposite sign with zero.
// [RULE11] The speed sign mode resets to 0, is used while the slave input is open and has the same codes.
// [RULE12] The speed bias spans from -400.0 percent of 10 V upward and resets to zero.
// [RULE13] All results are computed on each sample update with saturating arithmetic.
`timescale 1ns/100ps
`default_nettype none
module ris_top
  import ris_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic slave_mode_pin,
  input wire logic sample_valid,
  input wire logic signed [RIS_SAMPLE_W-1:0] main_sample,
  input wire logic signed [RIS_SAMPLE_W-1:0] aux1_sample,
  input wire logic signed [RIS_SAMPLE_W-1:0] aux2_sample,
  input wire logic signed [RIS_SAMPLE_W-1:0] aux3_sample,
  output logic signed [RIS_SAMPLE_W-1:0] main_ref,
  output logic main_ref_is_current,
  output logic signed [RIS_SAMPLE_W-1:0] aux1_ref,
  output logic signed [RIS_SAMPLE_W-1:0] aux2_ref,
  output logic signed [RIS_SAMPLE_W-1:0] aux3_ref,
  output logic ref_valid
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] ris_merge(input logic [15:0] old_val,
                                            input logic [31:0] wdata,
                                            input logic [3:0] be);
    logic [15:0] res;
    res = old_val;
    if (be[0])
      res[7:0] = wdata[7:0];
    if (be[1])
      res[15:8] = wdata[15:8];
    return res;
  endfunction : ris_merge

  // Out-of-range writes settle on the nearest limit rather than being dropped
  function automatic logic signed [15:0] ris_limit(input logic signed [15:0] val,
                                                   input logic signed [15:0] lo,
                                                   input logic signed [15:0] hi);
    logic signed [15:0] res;
    res = val;
    if (val > hi)
      res = hi;
    else if (val < lo)
      res = lo;
    return res;
  endfunction : ris_limit

  function automatic logic [1:0] ris_mode(input logic [15:0] val);
    logic [1:0] res;
    res = val[1:0];
    if (val > 16'(RIS_MODE_NEG_ONLY))
      res = RIS_MODE_NEG_ONLY;
    return res;
  endfunction : ris_mode

  // ----------------------------------------------------------------
  // Slave-mode pin synchroniser
  // ----------------------------------------------------------------
  logic slave_meta;
  logic slave_sync;

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      slave_meta <= 1'b0;
      slave_sync <= 1'b0;
    end
    else
    begin
      slave_meta <= slave_mode_pin;
      slave_sync <= slave_meta;
    end
  end

  // ----------------------------------------------------------------
  // Avalon-MM slave: one wait cycle per access
  // ----------------------------------------------------------------
  logic bus_ack;
  logic bus_req;
  logic wr_en;
  logic [7:0] word_addr;

  assign bus_req = avs_read | avs_write;
  assign avs_waitrequest = bus_req & ~bus_ack;
  assign wr_en = avs_write & bus_ack;
  assign word_addr = {avs_address[7:2], 2'b00};

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      bus_ack <= 1'b0;
    else
      bus_ack <= bus_req & ~bus_ack;
  end

  // ----------------------------------------------------------------
  // Main input settings
  // ----------------------------------------------------------------
  logic signed [15:0] speed_ref_gain;
  logic signed [15:0] speed_ref_offset;
  logic [1:0] speed_ref_sign_mode;
  logic signed [15:0] current_ref_gain;
  logic signed [15:0] current_ref_offset;
  logic [1:0] current_ref_sign_mode;

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      speed_ref_gain <= RIS_GAIN_RESET; // see [RULE2]
    else if (wr_en && word_addr == RIS_OFF_SPEED_GAIN)
      speed_ref_gain <= ris_limit(ris_merge(speed_ref_gain, avs_writedata, avs_byteenable),
                                  RIS_GAIN_MIN, RIS_GAIN_MAX); // see [RULE2]
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      speed_ref_offset <= RIS_BIAS_RESET; // see [RULE12]
    else if (wr_en && word_addr == RIS_OFF_SPEED_BIAS)
      speed_ref_offset <= ris_limit(ris_merge(speed_ref_offset, avs_writedata, avs_byteenable),
                                    RIS_BIAS_MIN, RIS_BIAS_MAX); // see [RULE12]
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      speed_ref_sign_mode <= RIS_MODE_RESET; // see [RULE11]
    else if (wr_en && word_addr == RIS_OFF_SPEED_POL)
      speed_ref_sign_mode <= ris_mode(ris_merge(16'(speed_ref_sign_mode), avs_writedata,
                                                avs_byteenable)); // see [RULE11]
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      current_ref_gain <= RIS_GAIN_RESET; // see [RULE7]
    else if (wr_en && word_addr == RIS_OFF_CURR_GAIN)
      current_ref_gain <= ris_limit(ris_merge(current_ref_gain, avs_writedata, avs_byteenable),
                                    RIS_GAIN_MIN, RIS_GAIN_MAX); // see [RULE7]
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      current_ref_offset <= RIS_BIAS_RESET; // see [RULE6]
    else if (wr_en && word_addr == RIS_OFF_CURR_BIAS)
      current_ref_offset <= ris_limit(ris_merge(current_ref_offset, avs_writedata,
                                                avs_byteenable),
                                      RIS_BIAS_MIN, RIS_BIAS_MAX); // see [RULE6]
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      current_ref_sign_mode <= RIS_MODE_RESET; // see [RULE4]
    else if (wr_en && word_addr == RIS_OFF_CURR_POL)
      current_ref_sign_mode <= ris_mode(ris_merge(16'(current_ref_sign_mode), avs_writedata,
                                                  avs_byteenable)); // see [RULE4]
  end

  // ----------------------------------------------------------------
  // Auxiliary input settings and channels
  // ----------------------------------------------------------------
  logic signed [15:0] aux_gain [RIS_AUX_N];
  logic signed [15:0] aux_offset [RIS_AUX_N];
  logic [1:0] aux_input_sign_mode [RIS_AUX_N];
  logic signed [RIS_SAMPLE_W-1:0] aux_sample [RIS_AUX_N];
  logic signed [RIS_SAMPLE_W-1:0] aux_out [RIS_AUX_N];

  assign aux_sample[0] = aux1_sample;
  assign aux_sample[1] = aux2_sample;
  assign aux_sample[2] = aux3_sample;
  assign aux1_ref = aux_out[0];
  assign aux2_ref = aux_out[1];
  assign aux3_ref = aux_out[2];

  genvar k;
  generate
    for (k = 0; k < RIS_AUX_N; k++)
    begin : g_aux
      localparam logic [7:0] OFF_G = 8'(RIS_OFF_AUX_BASE + 8'(k) * RIS_OFF_AUX_STRIDE);
      localparam logic [7:0] OFF_B = 8'(OFF_G + 8'h04);
      localparam logic [7:0] OFF_P = 8'(OFF_G + 8'h08);

      always_ff @(posedge sys_clk)
      begin
        if (srst)
          aux_gain[k] <= RIS_GAIN_RESET;
        else if (wr_en && word_addr == OFF_G)
          aux_gain[k] <= ris_limit(ris_merge(aux_gain[k], avs_writedata, avs_byteenable),
                                   RIS_GAIN_MIN, RIS_GAIN_MAX);
      end

      always_ff @(posedge sys_clk)
      begin
        if (srst)
          aux_offset[k] <= RIS_BIAS_RESET;
        else if (wr_en && word_addr == OFF_B)
          aux_offset[k] <= ris_limit(ris_merge(aux_offset[k], avs_writedata, avs_byteenable),
                                     RIS_BIAS_MIN, RIS_BIAS_MAX);
      end

      always_ff @(posedge sys_clk)
      begin
        if (srst)
          aux_input_sign_mode[k] <= RIS_MODE_RESET; // see [RULE9]
        else if (wr_en && word_addr == OFF_P)
          aux_input_sign_mode[k] <= ris_mode(ris_merge(16'(aux_input_sign_mode[k]),
                                                       avs_writedata,
                                                       avs_byteenable)); // see [RULE9]
      end

      ris_scale u_aux (
        .sys_clk(sys_clk),
        .srst(srst),
        .in_valid(sample_valid),
        .sample(aux_sample[k]),
        .gain(aux_gain[k]),
        .bias(aux_offset[k]),
        .sign_mode(aux_input_sign_mode[k]), // see [RULE9] see [RULE10]
        .out_ref(aux_out[k]),
        .out_valid()
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Main channel: the slave input picks the parameter set
  // ----------------------------------------------------------------
  logic signed [15:0] main_gain;
  logic signed [15:0] main_offset;
  logic [1:0] main_mode;

  // Set is chosen per sample; a pin change between samples takes effect at the next one
  always_comb
  begin
    if (slave_sync)
    begin
      main_gain = current_ref_gain; // see [RULE3]
      main_offset = current_ref_offset; // see [RULE3]
      main_mode = current_ref_sign_mode; // see [RULE4]
    end
    else
    begin
      main_gain = speed_ref_gain; // see [RULE1]
      main_offset = speed_ref_offset; // see [RULE1]
      main_mode = speed_ref_sign_mode; // see [RULE11]
    end
  end

  ris_scale u_main (
    .sys_clk(sys_clk),
    .srst(srst),
    .in_valid(sample_valid),
    .sample(main_sample),
    .gain(main_gain),
    .bias(main_offset),
    .sign_mode(main_mode), // see [RULE5]
    .out_ref(main_ref),
    .out_valid(ref_valid)
  );

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      main_ref_is_current <= 1'b0;
    else if (sample_valid)
      main_ref_is_current <= slave_sync; // see [RULE3]
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [31:0] next_readdata;

  always_comb
  begin
    next_readdata = '0;
    case (word_addr)
      RIS_OFF_SPEED_GAIN: next_readdata = {{16{speed_ref_gain[15]}}, speed_ref_gain};
      RIS_OFF_SPEED_BIAS: next_readdata = {{16{speed_ref_offset[15]}}, speed_ref_offset};
      RIS_OFF_SPEED_POL: next_readdata = {30'h0, speed_ref_sign_mode};
      RIS_OFF_CURR_GAIN: next_readdata = {{16{current_ref_gain[15]}}, current_ref_gain};
      RIS_OFF_CURR_BIAS: next_readdata = {{16{current_ref_offset[15]}}, current_ref_offset};
      RIS_OFF_CURR_POL: next_readdata = {30'h0, current_ref_sign_mode};
      RIS_OFF_STATUS: next_readdata = {30'h0, main_ref_is_current, slave_sync};
      RIS_OFF_MAIN_OUT: next_readdata = {{16{main_ref[15]}}, main_ref};
      default:
      begin
        for (int i = 0; i < RIS_AUX_N; i++)
        begin
          if (word_addr == 8'(RIS_OFF_AUX_BASE + 8'(i) * RIS_OFF_AUX_STRIDE))
            next_readdata = {{16{aux_gain[i][15]}}, aux_gain[i]};
          if (word_addr == 8'(RIS_OFF_AUX_BASE + 8'(i) * RIS_OFF_AUX_STRIDE + 8'h04))
            next_readdata = {{16{aux_offset[i][15]}}, aux_offset[i]};
          if (word_addr == 8'(RIS_OFF_AUX_BASE + 8'(i) * RIS_OFF_AUX_STRIDE + 8'h08))
            next_readdata = {30'h0, aux_input_sign_mode[i]};
          if (word_addr == 8'(RIS_OFF_AUX_OUT + 8'(i) * 8'h04))
            next_readdata = {{16{aux_out[i][15]}}, aux_out[i]};
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      avs_readdata <= '0;
    else if (avs_read && !bus_ack)
      avs_readdata <= next_readdata;
  end

endmodule : ris_top
`default_nettype wire

// >>> tb/ris_source_model.sv
// Partner: sample source feeding the block and regulator capturing its references
`timescale 1ns/100ps
`default_nettype none
module ris_source_model
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic go,
  input wire logic [3:0][15:0] x_in,
  input wire logic ref_valid,
  input wire logic [3:0][15:0] refs,
  output logic sample_valid,
  output logic [3:0][15:0] samples,
  output logic got,
  output logic [3:0][15:0] cap
);
  initial
  begin
    sample_valid = 1'b0;
    samples = '0;
    got = 1'b0;
    cap = '0;
  end
  // Samples toggle between updates, so a design that reads them late is caught
  always @(posedge sys_clk)
  begin
    sample_valid <= go & ~srst;
    samples <= go ? x_in : ~samples;
    got <= ref_valid;
    if (ref_valid)
      cap <= refs;
  end
endmodule : ris_source_model
`default_nettype wire

// >>> tb/ris_top_bench.sv
// Testbench: settings registers, scaling, saturation and sign modes
`timescale 1ns/100ps
`default_nettype none
module ris_top_bench;
  import ris_pkg::*;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic slave_mode_pin = 1'b0;
  logic sample_valid;
  logic signed [15:0] main_sample, aux1_sample, aux2_sample, aux3_sample;
  logic signed [15:0] main_ref, aux1_ref, aux2_ref, aux3_ref;
  logic main_ref_is_current, ref_valid, got;
  logic go = 1'b0;
  logic [3:0][15:0] x_in = '0;
  logic [3:0][15:0] cap;
  int failures = 0;
  int tests_run = 0;
  int seed = 45542;
  int gain [5];
  int bias [5];
  int mode [5];
  logic [31:0] rd;
  logic [7:0] ca [6] = '{8'h00, 8'h0C, 8'h04, 8'h10, 8'h08, 8'h50};
  int cw [6] = '{9000, -9000, 5000, -5000, 3, 7};
  int ce [6] = '{8000, -8000, 4000, -4000, 2, 0};

  always #2 sys_clk = ~sys_clk;
  ris_top ris_top_i (.*);
  ris_source_model ris_source_model_i (.sys_clk(sys_clk), .srst(srst), .go(go),
    .x_in(x_in), .ref_valid(ref_valid), .refs({aux3_ref, aux2_ref, aux1_ref, main_ref}),
    .sample_valid(sample_valid), .samples({aux3_sample, aux2_sample, aux1_sample,
    main_sample}), .got(got), .cap(cap));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] exp_ref(input longint x, input longint g,
                                          input longint b, input int m);
    longint v;
    v = (x * g + 16384 * b) / 1000;
    v = (v > 32767) ? 32767 : (v < -32768) ? -32768 : v;
    if ((m == 1 && v < 0) || (m == 2 && v > 0))
      v = 0;
    return v[15:0];
  endfunction : exp_ref

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic final_report;
    if (failures == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : final_report

  // The master holds the request until waitrequest is seen low at an edge
  task automatic wait_ack;
    int n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 20);
    check({31'h0, avs_waitrequest}, 32'h0);
    if (avs_waitrequest !== 1'b0)
      final_report();
  endtask : wait_ack

  task automatic av_write(input logic [7:0] a, input int d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    wait_ack();
    avs_write <= 1'b0;
  endtask : av_write

  task automatic av_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_read <= 1'b1;
    wait_ack();
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask : av_read

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    int k, i, d;
    logic [15:0] e;
    repeat (3) @(posedge sys_clk);
    srst <= 1'b0;
    for (k = 0; k < 15; k++)
    begin
      av_read(8'(k * 4), rd);
      check(rd, (k % 3 == 0) ? 32'h3E8 : 32'h0);
    end
    for (k = 0; k < 6; k++)
    begin
      av_write(ca[k], cw[k]);
      av_read(ca[k], rd);
      check(rd, ce[k]);
    end
    for (i = 0; i < 40; i++)
    begin
      for (k = 0; k < 5; k++)
      begin
        gain[k] = (i == 0 || i == 2) ? 8000 : $random(seed) % 8001;
        bias[k] = (i == 0) ? 4000 : (i == 2) ? -4000 : $random(seed) % 4001;
        mode[k] = (i < 3) ? i : (($random(seed) % 3) + 3) % 3;
        if (i == 1 && k == 1)
        begin
          gain[k] = 2000;
          bias[k] = 0;
        end
        av_write(8'(k * 12), gain[k]);
        av_write(8'(k * 12 + 4), bias[k]);
        av_write(8'(k * 12 + 8), mode[k]);
      end
      av_read(8'((i % 5) * 12), rd);
      check(rd, gain[i % 5]);
      d = (i == 1) ? 1 : $random(seed) & 1;
      for (k = 0; k < 4; k++)
        x_in[k] <= (i == 0) ? 16'h7FFF : (i == 2) ? 16'h8000 : 16'($random(seed));
      if (i == 1)
        x_in[0] <= 16'h2000;
      slave_mode_pin <= d[0];
      repeat (4) @(posedge sys_clk);
      go <= 1'b1;
      @(posedge sys_clk);
      go <= 1'b0;
      k = 0;
      while (got !== 1'b1 && k < 10)
      begin
        @(posedge sys_clk);
        k++;
      end
      check({31'h0, got}, 32'h1);
      if (got !== 1'b1)
        final_report();
      e = exp_ref($signed(x_in[0]), gain[d], bias[d], mode[d]);
      check(cap[0], e);
      check({31'h0, main_ref_is_current}, d);
      for (k = 1; k < 4; k++)
        check(cap[k], exp_ref($signed(x_in[k]), gain[k + 1], bias[k + 1], mode[k + 1]));
      av_read(8'h40, rd);
      check(rd[15:0], e);
      av_read(8'h3C, rd);
      check(rd[1:0], {d[0], d[0]});
    end
    srst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    srst <= 1'b0;
    av_read(8'h0C, rd);
    check(rd, 32'h3E8);
    check(main_ref, 32'h0);
    final_report();
  end
endmodule : ris_top_bench

bind ris_top ris_top_monitor ris_top_monitor_i (.*);
`default_nettype wire

// >>> tb/ris_top_monitor.sv
// Checker: port-level properties of the reference input scaling block
`timescale 1ns/100ps
`default_nettype none
module ris_top_monitor
  import ris_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic slave_mode_pin,
  input wire logic sample_valid,
  input wire logic signed [RIS_SAMPLE_W-1:0] main_sample,
  input wire logic signed [RIS_SAMPLE_W-1:0] aux1_sample,
  input wire logic signed [RIS_SAMPLE_W-1:0] aux2_sample,
  input wire logic signed [RIS_SAMPLE_W-1:0] aux3_sample,
  input wire logic signed [RIS_SAMPLE_W-1:0] main_ref,
  input wire logic main_ref_is_current,
  input wire logic signed [RIS_SAMPLE_W-1:0] aux1_ref,
  input wire logic signed [RIS_SAMPLE_W-1:0] aux2_ref,
  input wire logic signed [RIS_SAMPLE_W-1:0] aux3_ref,
  input wire logic ref_valid
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking mon_cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  wire logic req = avs_read | avs_write;
  wire logic rd_done = avs_read & ~avs_waitrequest;

  AST_ONE_WAIT: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  AST_WAIT_FIRST: assert property (req && !avs_waitrequest |-> $past(avs_waitrequest))
    else $error("bus answer without wait cycle");
  AST_IDLE: assert property (!req |-> !avs_waitrequest)
    else $error("wait raised while idle");
  AST_UNMAPPED: assert property (rd_done && avs_address >= 8'h50 |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  AST_MODE_RANGE: assert property (rd_done && avs_address inside {8'h08, 8'h14, 8'h20,
    8'h2C, 8'h38} |-> avs_readdata <= 32'h2)
    else $error("sign mode out of range");
  AST_GAIN_RANGE: assert property (rd_done && avs_address inside {8'h00, 8'h0C} |->
    $signed(avs_readdata) <= 32'sh1F40 && $signed(avs_readdata) >= -32'sh1F40)
    else $error("gain out of range");
  AST_VALID_NEXT: assert property (sample_valid |=> ref_valid)
    else $error("no result after sample");
  AST_VALID_ONLY: assert property (ref_valid |-> $past(sample_valid))
    else $error("result without sample");
  AST_REF_HOLD: assert property (!sample_valid |=> $stable(main_ref) && $stable(aux1_ref)
    && $stable(aux2_ref) && $stable(aux3_ref))
    else $error("reference moved without sample");
  AST_CURRENT_SEL: assert property (slave_mode_pin [*4] ##0 sample_valid |=>
    main_ref_is_current)
    else $error("closed input not current path");
  AST_SPEED_SEL: assert property (!slave_mode_pin [*4] ##0 sample_valid |=>
    !main_ref_is_current)
    else $error("open input not speed path");
  AST_RESET_VAL: assert property ($fell(srst) |-> !ref_valid && main_ref == 16'sh0000)
    else $error("outputs not cleared by reset");

  cover property (ref_valid && main_ref_is_current);
  cover property (ref_valid && main_ref == 16'sh7FFF);
  cover property (avs_write && !avs_waitrequest);
endmodule : ris_top_monitor
`default_nettype wire
